// file: udta_regs.vh
// Constants for the descriptor table access block
`ifndef UDTA_REGS_VH
`define UDTA_REGS_VH
// ============================================================
// Register offsets (byte addresses, 32-bit words)
`define UDTA_OFS_PAGE      8'h00
`define UDTA_OFS_CTRL      8'h04
`define UDTA_OFS_STATUS    8'h08
`define UDTA_OFS_LASTADDR  8'h0C
`define UDTA_OFS_DONECNT   8'h10
// ============================================================
// Control fields
`define UDTA_CTRL_EN_BIT   0
`define UDTA_CTRL_HOST_BIT 1
`define UDTA_CTRL_ODDRST   2
`define UDTA_CTRL_RST      32'h0000_0000
`define UDTA_PAGE_RST      24'h00_0000
// ============================================================
// Descriptor address layout
`define UDTA_ADDR_EP_LSB   5
`define UDTA_ADDR_DIR_BIT  4
`define UDTA_ADDR_ODD_BIT  3
// ============================================================
// Descriptor word 0 fields
`define UDTA_DESC_OWN_BIT  7
`define UDTA_DESC_KEEP_BIT 5
`define UDTA_DESC_BC_LSB   16
`define UDTA_DESC_BC_MSB   25
// ============================================================
// Token codes
`define UDTA_PID_OUT       4'h1
`define UDTA_PID_IN        4'h9
`define UDTA_PID_SETUP     4'hD
`endif

// file: udta_core.v
// Descriptor table addressing, ownership and word buffer
//
// Functional notes
// - Two eight-byte entries, even and odd, per endpoint direction.
// - Sixteen bidirectional endpoints through a four-bit endpoint field.
// - Address = page bytes, page low [7:1], endpoint, direction, bank, 000.
// - Direction bit is one for transmit, zero for receive.
// - Bank bit kept per endpoint direction, toggles ping-pong per used buffer.
// - Own zero: processor owns; own one: controller only, processor hands off.
// - Token on enabled endpoint fetches its descriptor, checks ownership first.
// - Device: rx=OUT/SETUP, tx=IN. Host: rx=IN, tx=OUT/SETUP.
// - One role at a time, switched only by software.
// - On completion write back, clear own unless keep, raise completion.
// - Other descriptor fields ignored while own reads zero.
// - Word 0: byte count bits 25:16, own bit 7; word 1 buffer address.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "udta_regs.vh"

module udta_core (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // Register port
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [31:0] o_reg_rdata,
  // Token from serial interface engine
  input  wire        i_tok_valid,
  input  wire [3:0]  i_tok_pid,
  input  wire [3:0]  i_tok_ep,
  input  wire        i_tok_done,
  input  wire [9:0]  i_tok_count,
  output reg         o_tok_ready,
  output reg         o_tok_refused,
  // Memory master
  output reg         o_mem_rd,
  output reg         o_mem_wr,
  output reg  [31:0] o_mem_addr,
  output reg  [31:0] o_mem_wdata,
  input  wire        i_mem_ack,
  input  wire [31:0] i_mem_rdata,
  // Data stream from engine
  input  wire        i_dat_valid,
  input  wire [31:0] i_dat_data,
  output reg         o_dat_ready,
  // Completion
  output reg         o_token_complete_irq
);

  // ============================================================
  // State codes
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD0  = 3'h1;
  localparam [2:0] ST_RD1  = 3'h2;
  localparam [2:0] ST_XFER = 3'h3;
  localparam [2:0] ST_WB   = 3'h4;

  // ============================================================
  // Helper functions
  function [31:0] desc_addr;
    input [23:0] page;
    input [3:0]  ep;
    input        dir;
    input        odd;
    begin
      desc_addr = {page[23:1], ep, dir, odd, 3'h0};
    end
  endfunction

  function is_tx;
    input [3:0] pid;
    input       host;
    begin
      if (host) begin
        is_tx = (pid == `UDTA_PID_OUT) || (pid == `UDTA_PID_SETUP);
      end else begin
        is_tx = (pid == `UDTA_PID_IN);
      end
    end
  endfunction

  function [4:0] bank_of;
    input [3:0] ep;
    input       dir;
    begin
      bank_of = {ep, dir};
    end
  endfunction

  function desc_owned;
    input [31:0] word0;
    begin
      desc_owned = word0[`UDTA_DESC_OWN_BIT];
    end
  endfunction

  function [31:0] next_word;
    input [31:0] addr;
    begin
      next_word = addr + 32'h0000_0004;
    end
  endfunction

  function reg_hit;
    input       strobe;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = strobe && (addr == ofs);
    end
  endfunction

  function [31:0] wb_word;
    input [31:0] word0;
    input [9:0]  count;
    input [3:0]  pid;
    begin
      if (word0[`UDTA_DESC_KEEP_BIT]) begin
        wb_word = word0;
      end else begin
        wb_word = {6'h00, count, 8'h00, 1'b0, word0[6], pid, 2'h0};
      end
    end
  endfunction

  function buf_room;
    input [1:0] cnt;
    input       push;
    input       pop;
    begin
      buf_room = (cnt == 2'h0) || ((cnt == 2'h1) && !push) || pop;
    end
  endfunction

  // ============================================================
  // Registers
  reg [23:0] page_r;
  reg        en_r;
  reg        host_r;
  reg [31:0] odd_r;
  reg [2:0]  state_r;
  reg [3:0]  ep_r;
  reg [3:0]  pid_r;
  reg        dir_r;
  reg [31:0] word0_r;
  reg [31:0] bufp_r;
  reg [31:0] last_addr_r;
  reg [15:0] done_cnt_r;
  reg        refused_r;
  reg        wb_stage_r;
  // Two-entry buffer
  reg [31:0] buf_d0_r;
  reg [31:0] buf_d1_r;
  reg [1:0]  buf_cnt_r;

  wire [4:0]  bank_idx = bank_of(ep_r, dir_r);
  wire        own      = desc_owned(word0_r);
  wire        buf_push = i_dat_valid && o_dat_ready &&
                         (state_r == ST_XFER);
  wire        buf_pop  = (buf_cnt_r != 2'h0) && !o_mem_wr && !o_mem_rd &&
                         (state_r == ST_XFER);

  // ============================================================
  // Token and register decode
  // A refusal pulse still sees the token valid, so no new take then
  wire        tok_take = i_tok_valid && en_r && !o_tok_refused &&
                         (state_r == ST_IDLE);
  wire        tok_dir  = is_tx(i_tok_pid, host_r);
  wire        tok_odd  = odd_r[bank_of(i_tok_ep, tok_dir)];
  wire        page_wr  = reg_hit(i_reg_wr, i_reg_addr, `UDTA_OFS_PAGE);
  wire        ctrl_wr  = reg_hit(i_reg_wr, i_reg_addr, `UDTA_OFS_CTRL);
  wire        odd_clr  = ctrl_wr && i_reg_wdata[`UDTA_CTRL_ODDRST];

  // ============================================================
  // Register port
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      page_r      <= `UDTA_PAGE_RST;
      en_r        <= 1'b0;
      host_r      <= 1'b0;
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      if (page_wr) begin
        page_r <= i_reg_wdata[23:0];
      end
      if (ctrl_wr) begin
        en_r <= i_reg_wdata[`UDTA_CTRL_EN_BIT];
        if (state_r == ST_IDLE) begin
          host_r <= i_reg_wdata[`UDTA_CTRL_HOST_BIT];
        end
      end
      o_reg_rdata <= 32'h0000_0000;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `UDTA_OFS_PAGE:     o_reg_rdata <= {8'h00, page_r[23:1], 1'b0};
          `UDTA_OFS_CTRL:     o_reg_rdata <= {30'h0000_0000, host_r, en_r};
          `UDTA_OFS_STATUS:   o_reg_rdata <= {25'h000_0000, refused_r, dir_r, ep_r, own};
          `UDTA_OFS_LASTADDR: o_reg_rdata <= last_addr_r;
          `UDTA_OFS_DONECNT:  o_reg_rdata <= {16'h0000, done_cnt_r};
          default:            o_reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ============================================================
  // Descriptor engine
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r              <= ST_IDLE;
      odd_r                <= 32'h0000_0000;
      ep_r                 <= 4'h0;
      pid_r                <= 4'h0;
      dir_r                <= 1'b0;
      word0_r              <= 32'h0000_0000;
      bufp_r               <= 32'h0000_0000;
      last_addr_r          <= 32'h0000_0000;
      done_cnt_r           <= 16'h0000;
      refused_r            <= 1'b0;
      wb_stage_r           <= 1'b0;
      o_tok_ready          <= 1'b0;
      o_tok_refused        <= 1'b0;
      o_mem_rd             <= 1'b0;
      o_mem_wr             <= 1'b0;
      o_mem_addr           <= 32'h0000_0000;
      o_mem_wdata          <= 32'h0000_0000;
      o_token_complete_irq <= 1'b0;
    end else begin
      o_tok_refused        <= 1'b0;
      o_token_complete_irq <= 1'b0;
      if (odd_clr) begin
        odd_r <= 32'h0000_0000;
      end
      case (state_r)
        ST_IDLE: begin
          o_tok_ready <= 1'b0;
          if (tok_take) begin
            ep_r        <= i_tok_ep;
            pid_r       <= i_tok_pid;
            dir_r       <= tok_dir;
            o_mem_addr  <= desc_addr(page_r, i_tok_ep, tok_dir, tok_odd);
            o_mem_rd    <= 1'b1;
            state_r     <= ST_RD0;
          end
        end
        ST_RD0: begin
          if (i_mem_ack) begin
            word0_r     <= i_mem_rdata;
            last_addr_r <= o_mem_addr;
            if (!desc_owned(i_mem_rdata)) begin
              o_mem_rd      <= 1'b0;
              refused_r     <= 1'b1;
              o_tok_refused <= 1'b1;
              state_r       <= ST_IDLE;
            end else begin
              o_mem_addr <= next_word(o_mem_addr);
              state_r    <= ST_RD1;
            end
          end
        end
        ST_RD1: begin
          if (i_mem_ack) begin
            o_mem_rd    <= 1'b0;
            bufp_r      <= i_mem_rdata;
            refused_r   <= 1'b0;
            o_tok_ready <= 1'b1;
            state_r     <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (o_mem_wr && i_mem_ack) begin
            o_mem_wr <= 1'b0;
            bufp_r   <= next_word(bufp_r);
          end else if (buf_pop) begin
            o_mem_wr    <= 1'b1;
            o_mem_addr  <= bufp_r;
            o_mem_wdata <= buf_d0_r;
          end else if (i_tok_done && buf_cnt_r == 2'h0 && !o_mem_wr) begin
            o_tok_ready <= 1'b0;
            o_mem_wr    <= 1'b1;
            o_mem_addr  <= last_addr_r;
            o_mem_wdata <= wb_word(word0_r, i_tok_count, pid_r);
            wb_stage_r  <= 1'b0;
            state_r     <= ST_WB;
          end
        end
        ST_WB: begin
          if (i_mem_ack) begin
            o_mem_wr                <= 1'b0;
            odd_r[bank_idx]         <= ~odd_r[bank_idx];
            done_cnt_r              <= done_cnt_r + 16'h0001;
            o_token_complete_irq    <= 1'b1;
            state_r                 <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Two-entry data buffer
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_d0_r    <= 32'h0000_0000;
      buf_d1_r    <= 32'h0000_0000;
      buf_cnt_r   <= 2'h0;
      o_dat_ready <= 1'b0;
    end else begin
      case ({buf_push, buf_pop})
        2'b10: begin
          if (buf_cnt_r == 2'h0) begin
            buf_d0_r <= i_dat_data;
          end else begin
            buf_d1_r <= i_dat_data;
          end
          buf_cnt_r <= buf_cnt_r + 2'h1;
        end
        2'b01: begin
          buf_d0_r  <= buf_d1_r;
          buf_cnt_r <= buf_cnt_r - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_r == 2'h1) begin
            buf_d0_r <= i_dat_data;
          end else begin
            buf_d0_r <= buf_d1_r;
            buf_d1_r <= i_dat_data;
          end
        end
        default: begin
          buf_cnt_r <= buf_cnt_r;
        end
      endcase
      o_dat_ready <= (state_r == ST_XFER) && buf_room(buf_cnt_r, buf_push, buf_pop);
    end
  end

endmodule
`default_nettype wire

// file: udta_mem_model.sv
// Memory partner that answers the block's descriptor and buffer accesses
`timescale 1ns/1ps
`default_nettype none
module udta_mem_model (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Access port
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  output var  logic        o_ack,
  output var  logic [31:0] o_rdata
);
  // ============================================================
  // Storage: eight-byte entries as word pairs, index from word address
  logic [31:0] mem [0:1023];
  integer      dly;
  integer      seed = 32'h5C31;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      dly   <= 0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
    end else if (i_rd || i_wr) begin
      if (dly == 0) begin
        o_ack   <= 1'b1;
        dly     <= $random(seed) & 3;
        o_rdata <= mem[i_addr[11:2]];
        if (i_wr) mem[i_addr[11:2]] <= i_wdata;
      end else begin
        dly <= dly - 1;
      end
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// file: udta_core_props.sv
// Port checker for the descriptor table access block
`timescale 1ns/1ps
`default_nettype none
module udta_core_props (
  // Watched ports
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_mem_ack,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic        o_tok_ready,
  input wire logic        o_tok_refused,
  input wire logic        o_token_complete_irq
);
  // ============================================================
  // Properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd_wait; o_mem_rd && !i_mem_ack; endsequence
  sequence s_wr_wait; o_mem_wr && !i_mem_ack; endsequence
  property p_rd_hold; s_rd_wait |=> o_mem_rd && $stable(o_mem_addr); endproperty
  property p_wr_hold; s_wr_wait |=> o_mem_wr && $stable(o_mem_wdata); endproperty
  property p_one_op; !(o_mem_rd && o_mem_wr); endproperty
  property p_ref_pulse; o_tok_refused |=> !o_tok_refused; endproperty
  property p_ref_cause; o_tok_refused |-> $past(i_mem_ack); endproperty
  property p_excl; !(o_tok_ready && o_tok_refused); endproperty
  property p_irq_pulse; o_token_complete_irq |=> !o_token_complete_irq; endproperty
  property p_irq_cause; o_token_complete_irq |-> $past(i_mem_ack) && !o_tok_ready; endproperty
  property p_wb_addr;
    $fell(o_tok_ready) |-> ##[0:1] (o_mem_wr && o_mem_addr[2:0] == 3'h0);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read dropped early");
  a_wr_hold: assert property (p_wr_hold) else $error("write dropped early");
  a_one_op: assert property (p_one_op) else $error("read and write together");
  a_ref_pulse: assert property (p_ref_pulse) else $error("refusal too long");
  a_ref_cause: assert property (p_ref_cause) else $error("refusal without fetch");
  a_excl: assert property (p_excl) else $error("ready and refused");
  a_irq_pulse: assert property (p_irq_pulse) else $error("completion too long");
  a_irq_cause: assert property (p_irq_cause) else $error("completion without write");
  a_wb_addr: assert property (p_wb_addr) else $error("bad write-back");
endmodule
bind udta_core udta_core_props u_props (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mem_ack(i_mem_ack), .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
  .o_tok_ready(o_tok_ready), .o_tok_refused(o_tok_refused),
  .o_token_complete_irq(o_token_complete_irq));
`default_nettype wire

// file: udta_core_tb_top.sv
// Testbench for the descriptor table access block
`timescale 1ns/1ps
`default_nettype none
module udta_core_tb_top;
  // ============================================================
  // Signals
  logic        clk = 0, rst = 1, wr = 0, rd = 0, tv = 0, td = 0, dv = 0, host = 0;
  logic [7:0]  ra = 8'h00;
  logic [31:0] wd = 32'h0, dd = 32'h0, odd = 32'h0, q [0:3];
  logic [3:0]  pid = 4'h0, ep = 4'h0;
  logic [9:0]  cnt = 10'h000;
  logic [23:0] page = 24'h0;
  wire  [31:0] rdat, ma, mwd, mrd;
  wire         trdy, tref, mr, mw, ack, drdy, irq;
  integer      n_mismatch = 0, total_checks = 0, seed = 32'hAB90, i, j, k, ndone = 0;
  always #2 clk = ~clk;
  udta_core dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_tok_valid(tv), .i_tok_pid(pid),
    .i_tok_ep(ep), .i_tok_done(td), .i_tok_count(cnt), .o_tok_ready(trdy),
    .o_tok_refused(tref), .o_mem_rd(mr), .o_mem_wr(mw), .o_mem_addr(ma), .o_mem_wdata(mwd),
    .i_mem_ack(ack), .i_mem_rdata(mrd), .i_dat_valid(dv), .i_dat_data(dd),
    .o_dat_ready(drdy), .o_token_complete_irq(irq));
  udta_mem_model mem (.i_ref_clk(clk), .i_rst(rst), .i_rd(mr), .i_wr(mw), .i_addr(ma),
    .i_wdata(mwd), .o_ack(ack), .o_rdata(mrd));
  // ============================================================
  // Helpers
  task chk(input [31:0] g, input [31:0] e); begin
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task reg_wr(input [7:0] a, input [31:0] d); begin
    @(posedge clk); ra <= a; wd <= d; wr <= 1;
    @(posedge clk); wr <= 0;
  end endtask
  task reg_rd(input [7:0] a, input [31:0] e); begin
    @(posedge clk); ra <= a; rd <= 1;
    @(posedge clk); rd <= 0;
    @(posedge clk); chk(rdat, e);
  end endtask
  function txd(input [3:0] p); txd = host ? (p != 4'h9) : (p == 4'h9); endfunction
  function [31:0] da(input [3:0] e, input d); da = {page[23:1], e, d, odd[{e, d}], 3'h0};
  endfunction
  task tok(input [3:0] p, input [3:0] e, input own, input keep);
    logic [31:0] a, w0;
    integer n;
    begin
      a = da(e, txd(p)); n = 1 + ($random(seed) & 3); w0 = {24'h0, own, 1'b1, keep, 5'h0};
      mem.mem[a[11:2]] = w0; mem.mem[a[11:2] + 1] = 32'h400; mem.mem[256] = 32'h5A5A5A5A;
      @(posedge clk); pid <= p; ep <= e; tv <= 1;
      k = 0; while (!mr && k < 50) begin @(posedge clk); k++; end
      chk(ma, a);
      k = 0; while (!trdy && !tref && k < 50) begin @(posedge clk); k++; end
      tv <= 0;
      chk(trdy, own);
      chk(tref, !own);
      if (own) begin
        for (i = 0; i < n; i++) begin
          q[i] = $random(seed); dv <= 1; dd <= q[i];
          @(posedge clk); k = 0; while (!drdy && k < 50) begin @(posedge clk); k++; end
        end
        dv <= 0; cnt <= $random(seed); td <= 1;
        k = 0; while (!irq && k < 200) begin @(posedge clk); k++; end
        td <= 0; chk(irq, 1);
        odd[{e, txd(p)}] = ~odd[{e, txd(p)}];
        ndone++;
        @(posedge clk);
        for (i = 0; i < n; i++) chk(mem.mem[256 + i], q[i]);
        chk(mem.mem[a[11:2]], keep ? w0 : {6'h0, cnt, 10'h001, p, 2'h0});
      end else begin
        @(posedge clk); chk(mem.mem[a[11:2]], w0);
        chk(mem.mem[256], 32'h5A5A5A5A);
      end
      reg_rd(8'h08, {25'h0, ~own, txd(p), e, own});
      reg_rd(8'h0C, a);
      reg_rd(8'h10, ndone);
    end
  endtask
  task report_and_stop; begin
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  // ============================================================
  // Sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    reg_rd(8'h04, 32'h0); reg_rd(8'h00, 32'h0); reg_rd(8'h40, 32'h0);
    page = $random(seed) & 24'hFFFFF0;
    reg_wr(8'h00, page); reg_rd(8'h00, page);
    @(posedge clk); tv <= 1; pid <= 4'h9;
    repeat (10) begin @(posedge clk); chk(mr, 0); end
    tv <= 0; reg_wr(8'h04, 32'h1);
    for (j = 0; j < 30; j++) begin
      if (j == 15) begin host = 1; reg_wr(8'h04, 32'h3); end
      if (j == 22) begin odd = 0; reg_wr(8'h07, 32'h0); reg_wr(8'h04, 32'h7); end
      tok((j % 3 == 0) ? 4'h1 : (j % 3 == 1) ? 4'h9 : 4'hD,
          (j % 8 == 7) ? 4'hF : j[1:0], (j % 5) != 4, (j % 7) == 3);
    end
    report_and_stop;
  end
  initial begin #40000; n_mismatch++; report_and_stop; end
endmodule
`default_nettype wire
